// >>> rtl/supply_fault_monitor_reset.sv
// Supply fault monitor, microcontroller reset sequencer and gate enable.
// Summary of operation
// (R1) Regulator undervoltage raises flag, sets sticky bit, forces gates low.
// (R2) Regulator recovery re-enables gates and clears flag; sticky bit stays.
// (R3) Regulator monitor works from reset; flag on and gates low until good.
// (R4) Regulator mask bit disables its monitor entirely.
// (R5) Controller supply low sets its sticky bit and pulls reset low.
// (R6) Controller supply low disables gates only when shutdown enable is 1.
// (R7) Controller supply low also sets the logic supply summary bit.
// (R8) Watchdog on: reset 10 ms, hold 100 ms, gates wait valid watchdog.
// (R9) Watchdog off: reset 10 ms, gates 10 ms later; valid serial ends early.
// (R10) I/O supply low: inputs inactive, gates low, sticky and summary set.
// (R11) I/O recovery: inputs back, gates wait 10 ms or valid serial transfer.
// (R12) Temperature warning raises flag and sets hot bit, no gate action.
// (R13) Temperature cooled: flag drops, hot bit stays until cleared.
// (R14) Watchdog fault latches, sets status bit, pulses reset low 10 ms.
// (R15) After pulse hold watchdog 100 ms; first valid watchdog clears fault.
// (R16) Enable input overrides gates; mask 1 direct, mask 0 timed mode.
// (R17) Timed mode: first enable edge arms gates; host must toggle again.
// (R18) Enable timeout: gates low, status bit, flag; next edge restores.
// (R19) Ignition level mirrored into status, never affects fault indication.
// (R20) Serial transfer valid only with 16 edges, odd parity, no save busy.
// (R21) Fault flag is the live OR of regulator, temperature, enable timeout and watchdog faults.
`timescale 1ns/1ps

module supply_fault_monitor_reset #(
  parameter logic [23:0] RST_HOLD_CYC = 24'(fault_mon_pkg::RST_HOLD_CYC),
  parameter logic [23:0] WDT_HOLD_CYC = 24'(fault_mon_pkg::WDT_HOLD_CYC),
  parameter logic [23:0] IO_HOLD_CYC = 24'(fault_mon_pkg::IO_HOLD_CYC),
  parameter logic [23:0] ETO_CYC = 24'(fault_mon_pkg::ETO_CYC)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire fault_mon_pkg::mon_s mon,
  input wire logic ignition_in,
  input wire logic enable_in,
  input wire logic [5:0] gate_cmd,
  input wire logic watchdog_fault_evt,
  input wire logic watchdog_valid_evt,
  input wire logic serial_end,
  input wire logic [4:0] serial_edge_cnt,
  input wire logic serial_parity_odd,
  input wire logic nvm_save_busy,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [5:0] gate_out,
  output logic mcu_reset_n,
  output logic fault_flag_n,
  output logic wdt_hold,
  output logic logic_inputs_ok
);

  // Reset sequencer states.
  typedef enum logic [5:0] {
    SEQ_UV = 6'h01,
    SEQ_RST = 6'h02,
    SEQ_WDH = 6'h04,
    SEQ_WAITWD = 6'h08,
    SEQ_DLY = 6'h10,
    SEQ_RUN = 6'h20
  } seq_e;

  seq_e seq_reg;
  seq_e seq_next;
  logic [23:0] seq_cnt_reg;
  logic [23:0] io_cnt_reg;
  logic [23:0] eto_cnt_reg;
  logic io_hold_reg;
  logic eto_active_reg;
  logic eto_expired_reg;
  logic enable_q_reg;
  logic wd_latched_reg;
  fault_mon_pkg::fault_flag_output_s fault_flag_output_reg;
  fault_mon_pkg::stat_s stat_reg;
  fault_mon_pkg::cfg_s cfg_reg;
  logic bus_req;
  logic bus_done;
  logic fault_flag_output_clr_hit;
  logic stat_clr_hit;
  logic gr_fault;
  logic serial_valid;
  logic serial_bad;
  logic enable_eff;
  logic enable_edge;
  logic [5:0] cmd_eff;
  logic seq_gate_ok;
  logic gate_ok;
  logic live_fault;
  logic [31:0] rd_mux;

  // Regulator monitor is live from reset and only the mask silences it.
  assign gr_fault = mon.gate_reg_uv & ~cfg_reg.vru_mask; // (R3) (R4)

  // Serial transfer qualification from the shift logic strobe release.
  assign serial_valid = serial_end & ~nvm_save_busy & serial_parity_odd
    & (serial_edge_cnt == 5'(fault_mon_pkg::SERIAL_EDGES)); // (R20)
  assign serial_bad = serial_end & ~serial_valid; // (R20)

  // Logic inputs read as inactive while the I/O supply is low.
  assign enable_eff = enable_in & ~mon.io_supply_uv; // (R10)
  assign cmd_eff = mon.io_supply_uv ? 6'h00 : gate_cmd; // (R10)
  assign enable_edge = enable_eff ^ enable_q_reg;

  // Live flag sources; ignition is deliberately absent from this term.
  assign live_fault = gr_fault | mon.temp_warn | eto_expired_reg
    | wd_latched_reg; // (R21) (R12) (R13) (R19)

  // Sequencer lets gates run once the controller is confirmed alive, or while controller supply is low with shutdown enable off.
  assign seq_gate_ok = (seq_reg == SEQ_RUN)
    | ((seq_reg == SEQ_UV) & ~cfg_reg.fault_shutdown_en); // (R6)

  // Enable override: direct level when masked, timer state otherwise.
  assign gate_ok = seq_gate_ok & ~gr_fault & ~mon.io_supply_uv & ~io_hold_reg
    & (cfg_reg.eto_mask ? enable_eff : eto_active_reg); // (R16) (R1) (R10)

  // Next state of the reset sequencer.
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_UV: begin
        if (!mon.ctrl_supply_uv) begin
          seq_next = SEQ_RST;
        end
      end
      SEQ_RST: begin
        if (cfg_reg.wd_mask && serial_valid) begin
          seq_next = SEQ_RUN; // (R9)
        end else if (seq_cnt_reg >= RST_HOLD_CYC - 24'h000001) begin
          seq_next = cfg_reg.wd_mask ? SEQ_DLY : SEQ_WDH; // (R8) (R9)
        end
      end
      SEQ_WDH: begin
        if (seq_cnt_reg >= WDT_HOLD_CYC - 24'h000001) begin
          seq_next = SEQ_WAITWD; // (R8) (R15)
        end
      end
      SEQ_WAITWD: begin
        if (watchdog_valid_evt) begin
          seq_next = SEQ_RUN; // (R15)
        end
      end
      SEQ_DLY: begin
        if (serial_valid || seq_cnt_reg >= RST_HOLD_CYC - 24'h000001) begin
          seq_next = SEQ_RUN; // (R9)
        end
      end
      SEQ_RUN: begin
        if (watchdog_fault_evt && !cfg_reg.wd_mask) begin
          seq_next = SEQ_RST; // (R14)
        end
      end
      default: seq_next = SEQ_UV;
    endcase
    if (mon.ctrl_supply_uv) begin
      seq_next = SEQ_UV; // (R5)
    end
  end

  // Sequencer state and its shared cycle counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_reg <= SEQ_UV;
      seq_cnt_reg <= 24'h000000;
    end else begin
      seq_reg <= seq_next;
      if (seq_next != seq_reg) begin
        seq_cnt_reg <= 24'h000000;
      end else begin
        seq_cnt_reg <= seq_cnt_reg + 24'h000001;
      end
    end
  end

  // Watchdog fault stays latched until the first valid watchdog after hold.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wd_latched_reg <= 1'b0;
    end else if (seq_reg == SEQ_RUN && seq_next == SEQ_RST) begin
      wd_latched_reg <= 1'b1; // (R14)
    end else if (seq_reg == SEQ_WAITWD && watchdog_valid_evt) begin
      wd_latched_reg <= 1'b0; // (R15)
    end
  end

  // I/O recovery hold: gates wait out the delay or a good serial transfer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_hold_reg <= 1'b0;
      io_cnt_reg <= 24'h000000;
    end else if (mon.io_supply_uv) begin
      io_hold_reg <= 1'b1;
      io_cnt_reg <= 24'h000000;
    end else if (io_hold_reg) begin
      io_cnt_reg <= io_cnt_reg + 24'h000001;
      if (serial_valid || io_cnt_reg >= IO_HOLD_CYC - 24'h000001) begin
        io_hold_reg <= 1'b0; // (R11)
      end
    end
  end

  // Enable activity timer; an edge arms the outputs and restarts it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_q_reg <= enable_eff; // Track the pin so release sees no edge.
      eto_active_reg <= 1'b0;
      eto_expired_reg <= 1'b0;
      eto_cnt_reg <= 24'h000000;
    end else begin
      enable_q_reg <= enable_eff;
      if (cfg_reg.eto_mask) begin
        eto_active_reg <= 1'b0;
        eto_expired_reg <= 1'b0;
        eto_cnt_reg <= 24'h000000;
      end else if (enable_edge) begin
        eto_active_reg <= 1'b1; // (R17) (R18)
        eto_expired_reg <= 1'b0; // (R18)
        eto_cnt_reg <= 24'h000000;
      end else if (eto_active_reg) begin
        eto_cnt_reg <= eto_cnt_reg + 24'h000001;
        if (eto_cnt_reg >= ETO_CYC - 24'h000001) begin
          eto_active_reg <= 1'b0; // (R18)
          eto_expired_reg <= 1'b1; // (R18)
        end
      end
    end
  end

  // Registered outputs toward the pins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_out <= 6'h00;
      mcu_reset_n <= 1'b0;
      fault_flag_n <= 1'b0;
      wdt_hold <= 1'b1;
      logic_inputs_ok <= 1'b0;
    end else begin
      gate_out <= gate_ok ? cmd_eff : 6'h00; // (R1) (R2) (R16)
      mcu_reset_n <= (seq_next != SEQ_UV) && (seq_next != SEQ_RST); // (R5)
      fault_flag_n <= ~live_fault; // (R1) (R2) (R12) (R13) (R21)
      wdt_hold <= (seq_next != SEQ_WAITWD) && (seq_next != SEQ_RUN); // (R8)
      logic_inputs_ok <= ~mon.io_supply_uv; // (R10) (R11)
    end
  end

  // Bus handshake: one wait cycle, then the access completes.
  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~avs_waitrequest;
  assign fault_flag_output_clr_hit = bus_done & avs_write
    & (avs_address == fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS);
  assign stat_clr_hit = bus_done & avs_write
    & (avs_address == fault_mon_pkg::STAT_OFS);

  // Sticky diagnostic bits; a set in the clearing cycle wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_flag_output_reg <= '0;
    end else begin
      fault_flag_output_reg.gate_reg_uv_bit <= gr_fault // (R1) (R2)
        | (fault_flag_output_reg.gate_reg_uv_bit
        & ~(fault_flag_output_clr_hit & avs_writedata[fault_mon_pkg::FAULT_FLAG_OUTPUT_GATE_REG_UV]));
      fault_flag_output_reg.ctrl_supply_uv_bit <= mon.ctrl_supply_uv // (R5)
        | (fault_flag_output_reg.ctrl_supply_uv_bit
        & ~(fault_flag_output_clr_hit & avs_writedata[fault_mon_pkg::FAULT_FLAG_OUTPUT_CTRL_UV]));
      fault_flag_output_reg.io_supply_uv_bit <= mon.io_supply_uv // (R10) (R11)
        | (fault_flag_output_reg.io_supply_uv_bit
        & ~(fault_flag_output_clr_hit & avs_writedata[fault_mon_pkg::FAULT_FLAG_OUTPUT_IO_UV]));
    end
  end

  // Sticky status bits, write one to clear; ignition is a live mirror.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg.summary_fault_bit <= live_fault | (stat_reg.summary_fault_bit
        & ~(stat_clr_hit & avs_writedata[fault_mon_pkg::STAT_FAULT])); // (R19)
      stat_reg.logic_supply_uv_summary <= mon.ctrl_supply_uv // (R7) (R10)
        | mon.io_supply_uv | (stat_reg.logic_supply_uv_summary
        & ~(stat_clr_hit & avs_writedata[fault_mon_pkg::STAT_LOGIC_UV]));
      stat_reg.hot_warning_bit <= mon.temp_warn // (R12) (R13)
        | (stat_reg.hot_warning_bit
        & ~(stat_clr_hit & avs_writedata[fault_mon_pkg::STAT_HOT]));
      stat_reg.watchdog_fault_bit <= (seq_reg == SEQ_RUN // (R14) (R15)
        && seq_next == SEQ_RST) | (stat_reg.watchdog_fault_bit
        & ~(stat_clr_hit & avs_writedata[fault_mon_pkg::STAT_WATCHDOG_INPUT]));
      stat_reg.enable_timeout_bit <= (eto_active_reg && !enable_edge
        && !cfg_reg.eto_mask && eto_cnt_reg >= ETO_CYC - 24'h000001)
        | (stat_reg.enable_timeout_bit
        & ~(stat_clr_hit & avs_writedata[fault_mon_pkg::STAT_ETO])); // (R18)
      stat_reg.ignition_state_bit <= ignition_in; // (R19)
      stat_reg.serial_error_bit <= serial_bad // (R20)
        | (stat_reg.serial_error_bit
        & ~(stat_clr_hit & avs_writedata[fault_mon_pkg::STAT_SERIAL]));
    end
  end

  // Configuration register written over the bus.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg <= fault_mon_pkg::CFG_RESET;
    end else if (bus_done && avs_write
        && avs_address == fault_mon_pkg::CFG_OFS) begin
      cfg_reg.vru_mask <= avs_writedata[fault_mon_pkg::CFG_VRU_MASK]; // (R4)
      cfg_reg.wd_mask <= avs_writedata[fault_mon_pkg::CFG_WD_MASK];
      cfg_reg.eto_mask <= avs_writedata[fault_mon_pkg::CFG_ETO_MASK]; // (R16)
      cfg_reg.fault_shutdown_en <= avs_writedata[fault_mon_pkg::CFG_ESF];
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_mux = 32'h00000000;
    if (avs_address == fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS) begin
      rd_mux = {29'h00000000, fault_flag_output_reg};
    end else if (avs_address == fault_mon_pkg::STAT_OFS) begin
      rd_mux = {25'h0000000, stat_reg};
    end else if (avs_address == fault_mon_pkg::CFG_OFS) begin
      rd_mux = {28'h0000000, cfg_reg};
    end
  end

  // Waitrequest drops for the single cycle that completes an access.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Regulator fault forces the gates off by the next edge.
  chk_gate_reg_off: assert property (@(posedge clk) disable iff (!rst_n)
    gr_fault |=> gate_out == 6'h00) else $error("gates on in reg uv"); // (R1)

  // Flag follows a live regulator fault and recovers with it.
  chk_flag_reg_uv: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(gr_fault) && !mon.temp_warn && !eto_expired_reg && !wd_latched_reg
    |=> fault_flag_n) else $error("flag stuck after recovery"); // (R2)

  // Masked regulator monitor leaves the diagnostic bit alone.
  chk_vru_mask: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_reg.vru_mask && !fault_flag_output_reg.gate_reg_uv_bit && !fault_flag_output_clr_hit
    |=> !fault_flag_output_reg.gate_reg_uv_bit) else $error("masked uv set bit"); // (R4)

  // Controller supply low drives reset low on the next edge.
  chk_ctrl_reset: assert property (@(posedge clk) disable iff (!rst_n)
    mon.ctrl_supply_uv |=> !mcu_reset_n && stat_reg.logic_supply_uv_summary)
    else $error("reset high during ctrl uv"); // (R5) (R7)

  // Watchdog hold follows reset release without a gap.
  chk_hold_after_rst: assert property (@(posedge clk) disable iff (!rst_n)
    seq_reg == SEQ_RST && seq_next == SEQ_WDH |=> mcu_reset_n && wdt_hold)
    else $error("hold missing after reset"); // (R8)

  // A watchdog fault latches and pulls reset low.
  chk_wd_fault: assert property (@(posedge clk) disable iff (!rst_n)
    seq_reg == SEQ_RUN && watchdog_fault_evt && !cfg_reg.wd_mask
    && !mon.ctrl_supply_uv |=> !mcu_reset_n && wd_latched_reg
    && stat_reg.watchdog_fault_bit) else $error("wd fault not taken"); // (R14)

  // I/O supply low zeroes the gates and the input buffers.
  chk_io_uv: assert property (@(posedge clk) disable iff (!rst_n)
    mon.io_supply_uv |=> gate_out == 6'h00 && !logic_inputs_ok)
    else $error("io uv not enforced"); // (R10)

  // Temperature warning sets flag and sticky bit together.
  chk_hot_warn: assert property (@(posedge clk) disable iff (!rst_n)
    mon.temp_warn |=> !fault_flag_n && stat_reg.hot_warning_bit)
    else $error("temp warning missed"); // (R12)

  // Ignition mirror lags the pin by one edge.
  chk_ign_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 stat_reg.ignition_state_bit == $past(ignition_in))
    else $error("ignition mirror wrong"); // (R19)

  // Bad serial transfer raises the error bit.
  chk_serial_err: assert property (@(posedge clk) disable iff (!rst_n)
    serial_end && serial_edge_cnt != 5'h10 |=> stat_reg.serial_error_bit)
    else $error("serial error not set"); // (R20)

  // Timeout expiry drops the outputs and raises the flag.
  chk_eto_expire: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(eto_expired_reg) |=> !fault_flag_n && (gate_out == 6'h00
    || cfg_reg.eto_mask)) else $error("eto expiry ignored"); // (R18)

endmodule

// >>> pkg/fault_mon_pkg.sv
// Shared constants and carrier types for the supply fault monitor.
package fault_mon_pkg;

  // Clock rate and timing figures.
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned RST_HOLD_MS = 10;
  localparam int unsigned WDT_HOLD_MS = 100;
  localparam int unsigned IO_HOLD_MS = 10;
  localparam int unsigned ETO_MS = 20;
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
  localparam int unsigned WDT_HOLD_CYC = WDT_HOLD_MS * CLK_KHZ;
  localparam int unsigned IO_HOLD_CYC = IO_HOLD_MS * CLK_KHZ;
  localparam int unsigned ETO_CYC = ETO_MS * CLK_KHZ;
  localparam int unsigned SERIAL_EDGES = 16;

  // Register byte offsets.
  localparam logic [3:0] FAULT_FLAG_OUTPUT_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] CFG_OFS = 4'h8;

  // Diagnostic register field positions.
  localparam int FAULT_FLAG_OUTPUT_GATE_REG_UV = 0;
  localparam int FAULT_FLAG_OUTPUT_CTRL_UV = 1;
  localparam int FAULT_FLAG_OUTPUT_IO_UV = 2;

  // Status register field positions.
  localparam int STAT_FAULT = 0;
  localparam int STAT_LOGIC_UV = 1;
  localparam int STAT_HOT = 2;
  localparam int STAT_WATCHDOG_INPUT = 3;
  localparam int STAT_ETO = 4;
  localparam int STAT_IGN = 5;
  localparam int STAT_SERIAL = 6;

  // Configuration register field positions and reset value.
  localparam int CFG_VRU_MASK = 0;
  localparam int CFG_WD_MASK = 1;
  localparam int CFG_ETO_MASK = 2;
  localparam int CFG_ESF = 3;
  localparam logic [3:0] CFG_RESET = 4'h8;

  // Sticky diagnostic bits.
  typedef struct packed {
    logic io_supply_uv_bit;
    logic ctrl_supply_uv_bit;
    logic gate_reg_uv_bit;
  } fault_flag_output_s;

  // Sticky status bits plus the live ignition mirror.
  typedef struct packed {
    logic serial_error_bit;
    logic ignition_state_bit;
    logic enable_timeout_bit;
    logic watchdog_fault_bit;
    logic hot_warning_bit;
    logic logic_supply_uv_summary;
    logic summary_fault_bit;
  } stat_s;

  // Software settings.
  typedef struct packed {
    logic fault_shutdown_en;
    logic eto_mask;
    logic wd_mask;
    logic vru_mask;
  } cfg_s;

  // Comparator and pin levels seen by the monitor.
  typedef struct packed {
    logic gate_reg_uv;
    logic ctrl_supply_uv;
    logic io_supply_uv;
    logic temp_warn;
  } mon_s;

endpackage

// >>> sim/mcu_model.sv
// Behavioural microcontroller on the far side of reset and watchdog.
`timescale 1ns/1ps
module mcu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mcu_reset_n,
  input wire logic wdt_hold,
  input wire logic send,
  input wire logic bad,
  output logic watchdog_valid_evt = 1'b0,
  output logic serial_end = 1'b0,
  output logic [4:0] serial_edge_cnt = 5'h0A,
  output logic serial_parity_odd = 1'b0
);
  logic [2:0] tick_reg = 3'h0;

  // Service the watchdog every eight cycles, never while held or in reset.
  always @(posedge clk) begin
    if (!rst_n || !mcu_reset_n || wdt_hold) begin
      tick_reg <= 3'h0;
      watchdog_valid_evt <= 1'b0;
    end else begin
      tick_reg <= tick_reg + 3'h1;
      watchdog_valid_evt <= (tick_reg == 3'h7);
    end
  end

  // Fields toggle between transfers so early sampling reads garbage.
  always @(posedge clk) begin
    serial_end <= send;
    if (send) begin
      serial_edge_cnt <= bad ? 5'h0F : 5'h10;
      serial_parity_odd <= 1'b1;
    end else begin
      serial_edge_cnt <= ~serial_edge_cnt;
      serial_parity_odd <= ~serial_parity_odd;
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the supply fault monitor and reset sequencer.
`timescale 1ns/1ps
module tb;
  // Short hold counts keep the run brief.
  localparam int RH = 20;
  localparam int WH = 40;
  localparam int IH = 20;
  localparam int EH = 30;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  fault_mon_pkg::mon_s mon = 4'h8;
  logic ignition_in = 1'b0;
  logic enable_in = 1'b1;
  logic [5:0] gate_cmd = 6'h2A;
  logic wd_fault = 1'b0;
  logic nvm_busy = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic send = 1'b0;
  logic bad = 1'b0;
  logic wd_valid, ser_end, par_odd, avs_waitrequest, mcu_reset_n;
  logic fault_flag_n, wdt_hold, logic_inputs_ok;
  logic [4:0] edge_cnt;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic [5:0] gate_out;
  int failures = 0;
  int num_checks = 0;
  int n;
  int k;

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  supply_fault_monitor_reset #(.RST_HOLD_CYC(24'(RH)),
    .WDT_HOLD_CYC(24'(WH)), .IO_HOLD_CYC(24'(IH)), .ETO_CYC(24'(EH))
  ) dut (.clk(clk), .rst_n(rst_n), .mon(mon), .ignition_in(ignition_in),
    .enable_in(enable_in), .gate_cmd(gate_cmd),
    .watchdog_fault_evt(wd_fault), .watchdog_valid_evt(wd_valid),
    .serial_end(ser_end), .serial_edge_cnt(edge_cnt),
    .serial_parity_odd(par_odd), .nvm_save_busy(nvm_busy),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gate_out(gate_out), .mcu_reset_n(mcu_reset_n),
    .fault_flag_n(fault_flag_n), .wdt_hold(wdt_hold),
    .logic_inputs_ok(logic_inputs_ok));

  mcu_model mcu (.clk(clk), .rst_n(rst_n), .mcu_reset_n(mcu_reset_n),
    .wdt_hold(wdt_hold), .send(send), .bad(bad),
    .watchdog_valid_evt(wd_valid), .serial_end(ser_end),
    .serial_edge_cnt(edge_cnt), .serial_parity_odd(par_odd));

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; the request holds until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      ck(32'h0, 32'h1);
      report_and_stop();
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rb(input logic [3:0] a, input int b, input logic e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    ck(32'(r[b]), 32'(e));
  endtask

  // Compares gates, reset, fault flag and watchdog hold together.
  task automatic co(input logic [5:0] g, input logic r, input logic f,
                    input logic h);
    ck(32'({gate_out, mcu_reset_n, fault_flag_n, wdt_hold}),
       32'({g, r, f, h}));
  endtask

  function automatic logic sg(input int s);
    case (s)
      0: return mcu_reset_n;
      1: return wdt_hold;
      default: return |gate_out;
    endcase
  endfunction

  // Bounded wait for an output level; the cycle count is returned.
  task automatic wt(input int s, input logic v, output int c);
    for (c = 0; c < 300; c++) begin
      if (sg(s) === v) break;
      @(posedge clk);
      #1;
    end
    if (c == 300) begin
      ck(32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  task automatic rng(input int c, input int lo, input int hi);
    ck(32'(c >= lo && c <= hi), 32'h1);
  endtask

  task automatic cy(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Main sequence; the regulator starts low to exercise power-up.
  initial begin
    cy(4);
    co(6'h00, 1'b0, 1'b0, 1'b1);
    @(posedge clk) rst_n <= 1'b1;
    bus(1'b0, fault_mon_pkg::CFG_OFS, 32'h0, q);
    ck(q, 32'h8);
    wr(fault_mon_pkg::CFG_OFS, 32'hC);
    co(6'h00, 1'b0, 1'b0, 1'b1);
    @(posedge clk) mon.gate_reg_uv <= 1'b0;
    wt(0, 1'b1, n);
    co(6'h00, 1'b1, 1'b1, 1'b1);
    wt(1, 1'b0, n);
    rng(n, WH - 2, WH + 2);
    co(6'h00, 1'b1, 1'b1, 1'b0);
    wt(2, 1'b1, n);
    co(6'h2A, 1'b1, 1'b1, 1'b0);
    @(posedge clk) mon.gate_reg_uv <= 1'b1;
    cy(2);
    co(6'h00, 1'b1, 1'b0, 1'b0);
    rb(fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS, fault_mon_pkg::FAULT_FLAG_OUTPUT_GATE_REG_UV, 1'b1);
    @(posedge clk) mon.gate_reg_uv <= 1'b0;
    cy(2);
    co(6'h2A, 1'b1, 1'b1, 1'b0);
    rb(fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS, fault_mon_pkg::FAULT_FLAG_OUTPUT_GATE_REG_UV, 1'b1);
    wr(fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS, 32'h1);
    rb(fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS, fault_mon_pkg::FAULT_FLAG_OUTPUT_GATE_REG_UV, 1'b0);
    wr(fault_mon_pkg::CFG_OFS, 32'hD);
    @(posedge clk) mon.gate_reg_uv <= 1'b1;
    cy(2);
    co(6'h2A, 1'b1, 1'b1, 1'b0);
    @(posedge clk) mon.gate_reg_uv <= 1'b0;
    wr(fault_mon_pkg::CFG_OFS, 32'hC);
    @(posedge clk) mon.temp_warn <= 1'b1;
    cy(2);
    co(6'h2A, 1'b1, 1'b0, 1'b0);
    @(posedge clk) mon.temp_warn <= 1'b0;
    cy(2);
    co(6'h2A, 1'b1, 1'b1, 1'b0);
    rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_HOT, 1'b1);
    @(posedge clk) ignition_in <= 1'b1;
    wr(fault_mon_pkg::STAT_OFS, 32'h7F);
    rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_IGN, 1'b1);
    rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_FAULT, 1'b0);
    co(6'h2A, 1'b1, 1'b1, 1'b0);
    @(posedge clk) ignition_in <= 1'b0;
    rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_IGN, 1'b0);
    @(posedge clk) wd_fault <= 1'b1;
    @(posedge clk) wd_fault <= 1'b0;
    cy(1);
    co(6'h00, 1'b0, 1'b0, 1'b1);
    wt(0, 1'b1, n);
    rng(n, RH - 3, RH + 1);
    co(6'h00, 1'b1, 1'b0, 1'b1);
    wt(1, 1'b0, n);
    rng(n, WH - 2, WH + 2);
    co(6'h00, 1'b1, 1'b0, 1'b0);
    wt(2, 1'b1, n);
    co(6'h2A, 1'b1, 1'b1, 1'b0);
    rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_WATCHDOG_INPUT, 1'b1);
    // Controller supply dip with shutdown enable off, then on.
    for (k = 0; k < 2; k++) begin
      wr(fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS, 32'h7);
      wr(fault_mon_pkg::STAT_OFS, 32'h7F);
      wr(fault_mon_pkg::CFG_OFS, 32'(k * 8 + 6));
      @(posedge clk) mon.ctrl_supply_uv <= 1'b1;
      cy(2);
      co(k ? 6'h00 : 6'h2A, 1'b0, 1'b1, 1'b1);
      rb(fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS, fault_mon_pkg::FAULT_FLAG_OUTPUT_CTRL_UV, 1'b1);
      rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_LOGIC_UV, 1'b1);
      @(posedge clk) mon.ctrl_supply_uv <= 1'b0;
      wt(0, 1'b1, n);
      rng(n, RH - 1, RH + 3);
      co(6'h00, 1'b1, 1'b1, 1'b1);
      if (k == 0) begin
        @(posedge clk) send <= 1'b1;
        @(posedge clk) send <= 1'b0;
        wt(2, 1'b1, n);
        rng(n, 0, 4);
      end else begin
        wt(2, 1'b1, n);
        rng(n, RH - 2, RH + 3);
      end
    end
    wr(fault_mon_pkg::CFG_OFS, 32'hC);
    wr(fault_mon_pkg::STAT_OFS, 32'h7F);
    @(posedge clk) mon.io_supply_uv <= 1'b1;
    cy(2);
    ck(32'(logic_inputs_ok), 32'h0);
    co(6'h00, 1'b1, 1'b1, 1'b0);
    rb(fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS, fault_mon_pkg::FAULT_FLAG_OUTPUT_IO_UV, 1'b1);
    rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_LOGIC_UV, 1'b1);
    @(posedge clk) mon.io_supply_uv <= 1'b0;
    cy(2);
    ck(32'({logic_inputs_ok, gate_out}), 32'h40);
    wt(2, 1'b1, n);
    rng(n, IH - 4, IH + 2);
    rb(fault_mon_pkg::FAULT_FLAG_OUTPUT_OFS, fault_mon_pkg::FAULT_FLAG_OUTPUT_IO_UV, 1'b1);
    // Timed enable mode, then direct mode.
    wr(fault_mon_pkg::CFG_OFS, 32'h8);
    @(posedge clk) enable_in <= !enable_in;
    cy(2);
    co(6'h2A, 1'b1, 1'b1, 1'b0);
    wt(2, 1'b0, n);
    rng(n, EH - 4, EH + 1);
    co(6'h00, 1'b1, 1'b0, 1'b0);
    rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_ETO, 1'b1);
    @(posedge clk) enable_in <= !enable_in;
    cy(2);
    co(6'h2A, 1'b1, 1'b1, 1'b0);
    wr(fault_mon_pkg::CFG_OFS, 32'hC);
    @(posedge clk) enable_in <= 1'b0;
    cy(2);
    co(6'h00, 1'b1, 1'b1, 1'b0);
    // Bad edge count, save in progress, then a clean transfer.
    for (k = 0; k < 3; k++) begin
      wr(fault_mon_pkg::STAT_OFS, 32'h7F);
      @(posedge clk) send <= 1'b1;
      bad <= (k == 0);
      nvm_busy <= (k == 1);
      @(posedge clk) send <= 1'b0;
      cy(2);
      rb(fault_mon_pkg::STAT_OFS, fault_mon_pkg::STAT_SERIAL, k < 2);
    end
    bus(1'b0, 4'hC, 32'h0, q);
    ck(q, 32'h0);
    report_and_stop();
  end
endmodule
